// *** sim/pbg_led_load.sv ***
// pbg_led_load.sv: rgb led load, remembers which colours lit and overlaps.
// assumes: led_rgb active high, clr synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module pbg_led_load
(
  input wire logic mclk,
  input wire logic clr,
  input wire logic [2:0] led_rgb,
  output logic [2:0] lit_seen,
  output logic multi_seen
);
  // passive load: sticky flags, so short flashes are not missed
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      lit_seen <= 3'h0;
      multi_seen <= 1'b0;
    end
    else
    begin
      lit_seen <= lit_seen | led_rgb;
      multi_seen <= multi_seen | ($countones(led_rgb) > 1);
    end
  end
endmodule
`default_nettype wire

// *** sim/pbg_top_monitor.sv ***
// pbg_top_monitor.sv: bus, breathing and one-shot assertions for pbg_top.
// assumes: bound to pbg_top, one clock mclk, rst_b active low.
`timescale 1ns/1ps
`default_nettype none

module pbg_top_monitor
  import pbg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic breath_enable_pin,
  input wire logic one_shot_trig,
  input wire logic one_shot_out,
  input wire logic breath_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ------------
  // sequences
  // ------------
  // address and data taken together
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // trigger moved in the last few samples; allows for an input sync stage
  sequence trig_moved;
    ($past(one_shot_trig) != $past(one_shot_trig, 2)) || ($past(one_shot_trig, 2) != $past(one_shot_trig, 3));
  endsequence

  // ------------
  // assertions
  // ------------
  write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  breath_hold_a: assert property (breath_enable_pin [*3] |-> !breath_out)
    else $error("breathing while held");
  shot_cause_a: assert property ($rose(one_shot_out) |-> trig_moved)
    else $error("pulse without trigger");
endmodule

bind pbg_top pbg_top_monitor pbg_top_monitor_i (.mclk, .rst_b, .breath_enable_pin, .one_shot_trig,
  .one_shot_out, .breath_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** sim/pbg_top_tb.sv ***
// pbg_top_tb.sv: self-checking bench for pbg_top over axi4-lite.
// assumes: pbg_defs.svh on the include path, led load model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "pbg_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module pbg_top_tb;
  logic mclk, rst_b, breath_enable_pin, one_shot_trig, pwm_out, one_shot_out, breath_out, clr, multi_seen;
  logic [2:0] led_rgb, lit_seen;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total, n_compared;

  pbg_top pbg_top_i (.mclk, .rst_b, .breath_enable_pin, .one_shot_trig, .pwm_out, .one_shot_out,
    .breath_out, .led_rgb, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pbg_led_load pbg_led_load_i (.mclk, .clr, .led_rgb, .lit_seen, .multi_seen);

  // ------------
  // clock, closing and watchdog
  // ------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // whole run is about 3600 cycles; a hung handshake lands here
  initial
  begin
    #600000;
    err_total++;
    print_verdict();
  end

  // ------------
  // bus tasks: one edge first, so strobes never change twice in a step
  // ------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        `CHK(s_axi_bresp, r)
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // ------------
  // scenarios
  // ------------
  // fixed pwm: low time is the delay, high time the rest of the period
  task automatic t_pwm(input logic [15:0] div, input logic [15:0] dly);
    int lo;
    int hi;
    wr(32'h04, {16'h0, div}, `PBG_RESP_OKAY);
    wr(32'h08, {16'h0, dly}, `PBG_RESP_OKAY);
    lo = 0;
    hi = 0;
    while (pwm_out !== 1'b1) @(posedge mclk);
    while (pwm_out !== 1'b0) @(posedge mclk);
    while (pwm_out === 1'b0)
    begin
      lo++;
      @(posedge mclk);
    end
    while (pwm_out === 1'b1)
    begin
      hi++;
      @(posedge mclk);
    end
    `CHK(lo, dly)
    `CHK(hi, div + 1 - dly)
  endtask
  // one-shot: rising then falling trigger, length OSLEN+1 when the edge is selected
  task automatic t_shot(input logic [1:0] mode);
    int hi;
    wr(32'h0c, 32'h4, `PBG_RESP_OKAY);
    wr(32'h00, {25'h0, 3'h7, 2'b01, mode}, `PBG_RESP_OKAY);
    for (int e = 0; e < 2; e++)
    begin
      hi = 0;
      one_shot_trig <= ~one_shot_trig;
      repeat (24)
      begin
        @(posedge mclk);
        hi += (one_shot_out === 1'b1);
      end
      `CHK(hi, ((e == 0 && mode == 2'h1) || (e == 1 && mode == 2'h0)) ? 0 : 5)
    end
  endtask
  // breathing with rgb sequencing, then host colour enables, then hold
  task automatic t_breath(input logic [31:0] ctrl, input logic [2:0] lit);
    int hi;
    wr(32'h10, 32'h7, `PBG_RESP_OKAY);
    wr(32'h14, 32'h8, `PBG_RESP_OKAY);
    wr(32'h00, ctrl, `PBG_RESP_OKAY);
    breath_enable_pin <= 1'b0;
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    // counters restart together: high time grows one cycle per period,
    // 1+2+...+8 = 36 of the 72 cycles before they coincide; the inverted
    // phase shows the complement, also 36, so any leftover phase passes
    hi = 0;
    @(posedge mclk);
    repeat (72)
    begin
      @(posedge mclk);
      hi += (breath_out === 1'b1);
    end
    `CHK(hi, 36)
    repeat (1227) @(posedge mclk);
    `CHK(lit_seen, lit)
    `CHK(multi_seen, 1'b0)
    breath_enable_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (200) @(posedge mclk);
    `CHK(lit_seen, 3'h0)
  endtask

  // ------------
  // main sequence
  // ------------
  initial
  begin
    {rst_b, one_shot_trig, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    breath_enable_pin = 1'b1;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(32'h00, `PBG_CTRL_RST, `PBG_RESP_OKAY);
    rd(32'h04, {16'h0, `PBG_DIV_RST}, `PBG_RESP_OKAY);
    rd(32'h08, {16'h0, `PBG_DLY_RST}, `PBG_RESP_OKAY);
    rd(32'h0c, {16'h0, `PBG_OSLEN_RST}, `PBG_RESP_OKAY);
    // status before the first divided edge: pwm high, colour index at range start
    rd(32'h18, {26'h0, `PBG_RANGE_START, 4'h1}, `PBG_RESP_OKAY);
    rd(32'h1c, 32'h0, `PBG_RESP_SLVERR);
    wr(32'h18, 32'hffff_ffff, `PBG_RESP_SLVERR);
    t_pwm(16'h003f, 16'h0020);
    t_pwm(16'h0009, 16'h0003);
    t_pwm(16'h0009, 16'h0009);
    for (int m = 0; m < 4; m++)
      t_shot(2'(m));
    t_breath(32'h0000_0074, 3'h7);
    t_breath(32'h0000_0028, 3'h2);
    print_verdict();
  end
endmodule
`default_nettype wire

// *** src/pbg_cnt.sv ***
// pbg_cnt.sv: counter cell giving one high cycle per programmed period.
// assumes: single clock mclk, data stable for a period; a change is compared with the running count at once.
`timescale 1ns/1ps
`default_nettype none
`include "pbg_defs.svh"

module pbg_cnt
  import pbg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic [`PBG_CW-1:0] cnt_data,
  output logic pulse
);

  logic [`PBG_CW-1:0] count_reg;

  // period is cnt_data+1 cycles; clear holds the count at zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= '0;
      pulse <= 1'b0;
    end
    else if (clr)
    begin
      count_reg <= '0;
      pulse <= 1'b0;
    end
    else if (count_reg >= cnt_data)
    begin
      count_reg <= '0;
      pulse <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      pulse <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** src/pbg_defs.svh ***
// pbg_defs.svh: register offsets, widths, reset values and counts
// of the pulse width and breathing generator.
// assumes: included by bare name from package and modules.
`ifndef PBG_DEFS_SVH
`define PBG_DEFS_SVH

// --------------------------------------------------------------------------
// register word indices, decoded from address bits 5:2 (byte address is four times)
// --------------------------------------------------------------------------
`define PBG_OFF_CTRL 4'h0
`define PBG_OFF_DIV 4'h1
`define PBG_OFF_DLY 4'h2
`define PBG_OFF_OSLEN 4'h3
`define PBG_OFF_BPER 4'h4
`define PBG_OFF_BDUTY 4'h5
`define PBG_OFF_STAT 4'h6

// --------------------------------------------------------------------------
// widths, reset values and counts
// --------------------------------------------------------------------------
`define PBG_CW 16
// period of OSC/64: divider counts data+1 cycles
`define PBG_DIV_RST 16'h003f
// half of the period gives 50 % duty
`define PBG_DLY_RST 16'h0020
`define PBG_OSLEN_RST 16'h0010
`define PBG_BPER_RST 16'h00ff
`define PBG_BDUTY_RST 16'h0100
`define PBG_CTRL_RST 32'h0000_0074
// phase offset added by the multifunction cell in host mode
`define PBG_OFFSET 16'h0001
`define PBG_RANGE_START 2'h1
`define PBG_RANGE_END 2'h3

// --------------------------------------------------------------------------
// bus answers
// --------------------------------------------------------------------------
`define PBG_RESP_OKAY 2'h0
`define PBG_RESP_SLVERR 2'h2

`endif

// *** src/pbg_pkg.sv ***
// pbg_pkg.sv: types of the pulse width and breathing generator.
// assumes: pbg_defs.svh on the include path.
`include "pbg_defs.svh"

package pbg_pkg;

  // one-shot trigger edge
  typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h2, EDGE_BOTH2 = 2'h3} pbg_edge_t;

  // one-shot state
  typedef enum logic {OS_IDLE, OS_PULSE} pbg_os_t;

  // control register layout
  typedef struct packed {
    logic [24:0] rsvd;
    logic [2:0] colour_en;
    logic host_var;
    logic rgb_seq;
    pbg_edge_t os_edge;
  } pbg_ctrl_t;

  // status register layout
  typedef struct packed {
    logic [24:0] rsvd;
    logic [1:0] colour_idx;
    logic phase;
    logic breath;
    logic one_shot;
    logic pwm;
  } pbg_stat_t;

endpackage

// *** src/pbg_top.sv ***
// pbg_top.sv: fixed-duty pwm, one-shot and breathing rgb generator
// with an axi4-lite register slave.
// assumes: one 50 MHz clock mclk, inputs synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "pbg_defs.svh"

// Notes on behaviour
// - edge detector idles high, drops low once per divided period rising edge.
// - detector low pulse forces delay output low until delay count elapses.
// - pwm period comes from the divider, OSC/64 by default; delay stays shorter.
// - high fraction is period minus delay over period; half delay gives 50%.
// - one-shot gives one pulse of preset length, then idles until retriggered.
// - one-shot length is the programmed counter data plus one cycle.
// - one-shot triggers on rising, falling or both input edges.
// - each breathing counter gives a one-cycle high pulse per period.
// - first counter pulse sets the flop, second resets it; data differ slightly.
// - coinciding pulses end the breathing cycle and toggle the phase flop.
// - exclusive-nor inverts pwm in alternate phases for ramp up and down.
// - enable pin high holds both breathing counters in reset.
// - colour counter cycles 1 to 3 and routes breathing to one colour.
// - host variant takes breathing period from host-written period data.
// - host variant uses equal data plus a small inserted offset.
// - host writes colour enables and counter data singly or together.
module pbg_top
  import pbg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic breath_enable_pin,
  input wire logic one_shot_trig,
  output logic pwm_out,
  output logic one_shot_out,
  output logic breath_out,
  output logic [2:0] led_rgb,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------------------
  // registers and internal state
  // ------------------------------------------------------------------------
  pbg_ctrl_t ctrl_reg;
  logic [`PBG_CW-1:0] div_reg, dly_reg, oslen_reg, bper_reg, bduty_reg;
  logic aw_have_reg, w_have_reg;
  logic [3:0] aw_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic tap_pulse, tap_reg, edge_ff_reg, edge_n_reg;
  logic [`PBG_CW-1:0] dly_cnt_reg, os_cnt_reg;
  logic trig_prev_reg, trig_hit;
  pbg_os_t os_state_reg;
  logic pulse_a, pulse_b, breath_ff_reg, phase_reg;
  logic [`PBG_CW-1:0] dataa, datab;
  logic [1:0] colour_idx_reg;
  logic [3:0] ar_idx;
  logic breath_sig;
  pbg_stat_t stat;

  // ------------------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------------------
  // address and data are taken in either order, one write in flight
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_idx_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBG_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[5:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx_reg <= `PBG_OFF_BDUTY) ? `PBG_RESP_OKAY : `PBG_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // register store; any subset of fields may change in one write
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= `PBG_CTRL_RST;
      div_reg <= `PBG_DIV_RST;
      dly_reg <= `PBG_DLY_RST;
      oslen_reg <= `PBG_OSLEN_RST;
      bper_reg <= `PBG_BPER_RST;
      bduty_reg <= `PBG_BDUTY_RST;
    end
    else if (aw_have_reg && w_have_reg && !s_axi_bvalid)
    begin
      case (aw_idx_reg)
        `PBG_OFF_CTRL:
        begin
          if (wstrb_reg[0])
          begin
            ctrl_reg[7:0] <= {1'b0, wdata_reg[6:0]};
          end
        end
        `PBG_OFF_DIV: div_reg <= merge16(div_reg);
        `PBG_OFF_DLY: dly_reg <= merge16(dly_reg);
        `PBG_OFF_OSLEN: oslen_reg <= merge16(oslen_reg);
        `PBG_OFF_BPER: bper_reg <= merge16(bper_reg);
        `PBG_OFF_BDUTY: bduty_reg <= merge16(bduty_reg);
        default: ;
      endcase
    end
  end

  // byte-lane merge of the low half word
  function automatic logic [`PBG_CW-1:0] merge16(input logic [`PBG_CW-1:0] old);
    merge16 = old;
    if (wstrb_reg[0])
      merge16[7:0] = wdata_reg[7:0];
    if (wstrb_reg[1])
      merge16[15:8] = wdata_reg[15:8];
  endfunction

  // ------------------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------------------
  assign ar_idx = s_axi_araddr[5:2];
  assign stat = '{rsvd: '0, colour_idx: colour_idx_reg, phase: phase_reg,
                  breath: breath_out, one_shot: one_shot_out, pwm: pwm_out};

  // answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PBG_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 : (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (ar_idx <= `PBG_OFF_STAT) ? `PBG_RESP_OKAY : `PBG_RESP_SLVERR;
        case (ar_idx)
          `PBG_OFF_CTRL: s_axi_rdata <= ctrl_reg;
          `PBG_OFF_DIV: s_axi_rdata <= {16'h0000, div_reg};
          `PBG_OFF_DLY: s_axi_rdata <= {16'h0000, dly_reg};
          `PBG_OFF_OSLEN: s_axi_rdata <= {16'h0000, oslen_reg};
          `PBG_OFF_BPER: s_axi_rdata <= {16'h0000, bper_reg};
          `PBG_OFF_BDUTY: s_axi_rdata <= {16'h0000, bduty_reg};
          `PBG_OFF_STAT: s_axi_rdata <= stat;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------------
  // fixed-duty pwm: divider, edge detector, delay counter
  // ------------------------------------------------------------------------
  // divider period is div_reg+1 cycles
  pbg_cnt u_div
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(1'b0),
    .cnt_data(div_reg),
    .pulse(tap_pulse)
  );

  // tap flop, edge flop and inverted detector output
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tap_reg <= 1'b0;
      edge_ff_reg <= 1'b0;
      edge_n_reg <= 1'b1;
    end
    else
    begin
      tap_reg <= tap_pulse;
      edge_ff_reg <= tap_reg;
      edge_n_reg <= !(tap_reg && !edge_ff_reg);
    end
  end

  // low for dly_reg cycles after each detector pulse; a delay not below
  // the period keeps the output low, so software keeps it shorter
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_cnt_reg <= '0;
      pwm_out <= 1'b0;
    end
    else if (!edge_n_reg)
    begin
      dly_cnt_reg <= dly_reg;
      pwm_out <= 1'b0;
    end
    else if (dly_cnt_reg != '0)
    begin
      dly_cnt_reg <= dly_cnt_reg - 1'b1;
      pwm_out <= (dly_cnt_reg == 16'h0001);
    end
    else
    begin
      pwm_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------------------
  // retriggerable one-shot
  // ------------------------------------------------------------------------
  always_comb
  begin
    case (ctrl_reg.os_edge)
      EDGE_RISE: trig_hit = one_shot_trig && !trig_prev_reg;
      EDGE_FALL: trig_hit = !one_shot_trig && trig_prev_reg;
      default: trig_hit = one_shot_trig != trig_prev_reg;
    endcase
  end

  // pulse stands oslen_reg+1 cycles; a new trigger restarts it
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trig_prev_reg <= 1'b0;
      os_state_reg <= OS_IDLE;
      os_cnt_reg <= '0;
      one_shot_out <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= one_shot_trig;
      if (trig_hit)
      begin
        os_state_reg <= OS_PULSE;
        os_cnt_reg <= oslen_reg;
        one_shot_out <= 1'b1;
      end
      else
      begin
        case (os_state_reg)
          OS_PULSE:
          begin
            if (os_cnt_reg == '0)
            begin
              os_state_reg <= OS_IDLE;
              one_shot_out <= 1'b0;
            end
            else
            begin
              os_cnt_reg <= os_cnt_reg - 1'b1;
            end
          end
          default:
          begin
            one_shot_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------------
  // breathing generator
  // ------------------------------------------------------------------------
  // host variant: equal data, offset cell adds a fixed extra count
  assign dataa = bper_reg;
  assign datab = ctrl_reg.host_var ? bper_reg + `PBG_OFFSET : bduty_reg;

  pbg_cnt u_cnta
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(breath_enable_pin),
    .cnt_data(dataa),
    .pulse(pulse_a)
  );

  pbg_cnt u_cntb
  (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(breath_enable_pin),
    .cnt_data(datab),
    .pulse(pulse_b)
  );

  // set by the first counter, reset by the second; coincidence ends the
  // cycle, toggles the phase and steps the colour counter after ramp-down
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breath_ff_reg <= 1'b0;
      phase_reg <= 1'b0;
      colour_idx_reg <= `PBG_RANGE_START;
    end
    else if (breath_enable_pin)
    begin
      breath_ff_reg <= 1'b0;
    end
    else if (pulse_a && pulse_b)
    begin
      breath_ff_reg <= 1'b0;
      phase_reg <= !phase_reg;
      if (phase_reg)
      begin
        colour_idx_reg <= (colour_idx_reg >= `PBG_RANGE_END) ? `PBG_RANGE_START : colour_idx_reg + 1'b1;
      end
    end
    else if (pulse_b)
    begin
      breath_ff_reg <= 1'b0;
    end
    else if (pulse_a)
    begin
      breath_ff_reg <= 1'b1;
    end
  end

  // soft-off inverter flips the pwm in the second phase
  assign breath_sig = !(breath_ff_reg ^ !phase_reg);

  // colour routing: sequencer or host enables through the multiplexer
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      breath_out <= 1'b0;
      led_rgb <= 3'h0;
    end
    else
    begin
      breath_out <= breath_sig && !breath_enable_pin;
      for (int i = 0; i < 3; i++)
      begin
        if (ctrl_reg.rgb_seq)
          led_rgb[i] <= breath_sig && !breath_enable_pin && (colour_idx_reg == 2'(i + 1));
        else
          led_rgb[i] <= breath_sig && !breath_enable_pin && ctrl_reg.colour_en[i];
      end
    end
  end

endmodule

`default_nettype wire
